// file: design/afc_map.svh
// afc_map.svh: byte codes, frame offsets, register map and timing for the frame codec host.
// assumes a 50 MHz aclk; included by the package and the design modules.
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH

// frame bytes
`define AFC_START_BYTE      8'h7E
`define AFC_TYPE_TX         8'h20
`define AFC_TYPE_SEND       8'h28
`define AFC_TYPE_DRESP      8'h2A
`define AFC_TYPE_DREQ       8'hB9
`define AFC_TYPE_LEGACY     8'h80
`define AFC_SUM_BASE        8'hFF
`define AFC_LEGACY_FMT      2'h2
`define AFC_CT_MAX          8'h10
`define AFC_OPT_MAX         8'h03
`define AFC_PROTO_MAX       8'h01
`define AFC_TXOPT_RSVD      8'hFD
`define AFC_TX_PAYLOAD_MAX  11'h578
`define AFC_TX_FIXED        11'h00A

// received frame offsets
`define AFC_OFF_TYPE        11'h003
`define AFC_OFF_REQID       11'h005
`define AFC_OFF_ADDR_FIRST  11'h004
`define AFC_OFF_ADDR_LAST   11'h00B
`define AFC_OFF_RSSI        11'h00C
`define AFC_OFF_ROPT        11'h00D
`define AFC_OFF_PAYLOAD     11'h00E

// transmit buffer holds frame bytes from offset 5 onward, from offset 7 in a device response
`define AFC_BUF_DEPTH       11'h020
`define AFC_BUF_PROTO       5'h08
`define AFC_BUF_TXOPT       5'h09
`define AFC_HDR_PLAIN       11'h002
`define AFC_HDR_DRESP       11'h004
`define AFC_RXBUF_DEPTH     11'h010

// register byte offsets
`define AFC_REG_CTRL        8'h00
`define AFC_REG_ID          8'h04
`define AFC_REG_TXLEN       8'h08
`define AFC_REG_TXDATA      8'h0C
`define AFC_REG_STATUS      8'h10
`define AFC_REG_CONFIG      8'h14
`define AFC_REG_SRC_HI      8'h18
`define AFC_REG_SRC_LO      8'h1C
`define AFC_REG_RXINFO      8'h20
`define AFC_REG_REQID       8'h24
`define AFC_RXWIN_SEL       2'h1

// field positions
`define AFC_CTRL_GO         0
`define AFC_ST_BUSY         0
`define AFC_ST_RXRDY        1
`define AFC_ST_PEND         2
`define AFC_ST_BADSUM       3
`define AFC_ST_REJECT       4
`define AFC_ST_LATE         5
`define AFC_ST_LEGACY       6

// reset values and bus answers
`define AFC_FMT_RST         2'h0
`define AFC_RESP_OKAY       2'h0
`define AFC_RESP_DECERR     2'h3

// timing
`define AFC_CLK_HZ          50000000
`define AFC_RESP_TIME_S     5
`define AFC_RESP_CYCLES     (`AFC_RESP_TIME_S * `AFC_CLK_HZ)

`endif

// file: design/afc_pkg.sv
// afc_pkg: state, carrier and state-record types of the frame codec host.
// assumes afc_map.svh is on the include path.
`include "afc_map.svh"
package afc_pkg;
  typedef enum logic [5:0] {
    AFC_TX_IDLE   = 6'h01,
    AFC_TX_START  = 6'h02,
    AFC_TX_LEN_HI = 6'h04,
    AFC_TX_LEN_LO = 6'h08,
    AFC_TX_BODY   = 6'h10,
    AFC_TX_SUM    = 6'h20
  } afc_tx_state_type;

  typedef enum logic [4:0] {
    AFC_RX_HUNT   = 5'h01,
    AFC_RX_LEN_HI = 5'h02,
    AFC_RX_LEN_LO = 5'h04,
    AFC_RX_DATA   = 5'h08,
    AFC_RX_SUM    = 5'h10
  } afc_rx_state_type;

  typedef enum logic [1:0] {
    AFC_KIND_TX    = 2'h0,
    AFC_KIND_SEND  = 2'h1,
    AFC_KIND_DRESP = 2'h2,
    AFC_KIND_BAD   = 2'h3
  } afc_kind_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } afc_byte_type;

  typedef struct packed {
    logic        strobe;
    logic        done;
    logic        good;
    logic [10:0] offset;
    logic [7:0]  value;
  } afc_event_type;

  typedef struct packed {
    afc_rx_state_type st;
    logic [15:0]      len;
    logic [15:0]      cnt;
    logic [7:0]       sum;
    afc_event_type    ev;
  } afc_parse_state_type;

  typedef struct packed {
    afc_tx_state_type  st;
    afc_kind_type      kind;
    logic [7:0]        frame_id;
    logic [10:0]       tx_len;
    logic [4:0]        tx_wptr;
    logic [31:0][7:0]  tx_mem;
    logic [10:0]       idx;
    logic [7:0]        csum;
    afc_byte_type      out;
    logic [1:0]        fmt;
    logic [7:0]        rtype;
    logic [63:0]       src;
    logic [7:0]        rssi;
    logic [7:0]        ropt;
    logic [10:0]       rx_cnt;
    logic [15:0][7:0]  rx_mem;
    logic              rx_ready;
    logic              legacy_seen;
    logic              bad_sum;
    logic              rejected;
    logic [7:0]        req_id_work;
    logic [7:0]        req_id;
    logic              req_pending;
    logic              late;
    logic [27:0]       timer;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } afc_host_state_type;
endpackage

// file: design/afc_rx_parser.sv
// afc_rx_parser: finds frames in the incoming byte stream and reports each body byte.
// assumes bytes arrive unescaped from serial logic on aclk, one per valid cycle.
`include "afc_map.svh"
module afc_rx_parser
  import afc_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire afc_byte_type  rx,
  output afc_event_type      ev
);
  afc_parse_state_type s;
  afc_parse_state_type next_s;

  assign ev = s.ev;

  always_comb begin
    next_s = s;
    next_s.ev.strobe = 1'b0;
    next_s.ev.done = 1'b0;
    if (rx.valid) begin
      unique case (s.st)
        AFC_RX_HUNT: begin
          // only a start byte leaves the hunt, so a bad frame resyncs here
          if (rx.data == `AFC_START_BYTE) begin
            next_s.st = AFC_RX_LEN_HI;
          end
        end
        AFC_RX_LEN_HI: begin
          next_s.len[15:8] = rx.data;
          next_s.st = AFC_RX_LEN_LO;
        end
        AFC_RX_LEN_LO: begin
          next_s.len[7:0] = rx.data;
          next_s.cnt = 16'h0000;
          next_s.sum = 8'h00;
          next_s.st = ({s.len[15:8], rx.data} == 16'h0000) ? AFC_RX_SUM : AFC_RX_DATA;
        end
        AFC_RX_DATA: begin
          next_s.ev.strobe = 1'b1;
          next_s.ev.offset = s.cnt[10:0] + `AFC_OFF_TYPE;
          next_s.ev.value = rx.data;
          next_s.sum = s.sum + rx.data;
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt + 16'h0001 == s.len) begin
            next_s.st = AFC_RX_SUM;
          end
        end
        AFC_RX_SUM: begin
          next_s.ev.done = 1'b1;
          next_s.ev.good = ((`AFC_SUM_BASE - s.sum) == rx.data);
          next_s.st = AFC_RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= AFC_RX_HUNT;
    end else begin
      s <= next_s;
    end
  end
endmodule

// file: design/afc_host_ctrl.sv
// afc_host_ctrl: host-side framer and parser for the module's serial frames, AXI4-Lite regs.
// assumes unescaped serial bytes on aclk; software fills the buffer, then writes go.
`include "afc_map.svh"
module afc_host_ctrl
  import afc_pkg::*;
#(
  parameter int unsigned RESP_TIMEOUT_CYCLES = `AFC_RESP_CYCLES
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output afc_byte_type       ser_tx,
  input  wire logic          ser_tx_ready,
  input  wire afc_byte_type  ser_rx
);
  afc_host_state_type s;
  afc_host_state_type next_s;
  afc_event_type      ev;
  logic [4:0]         ct_idx;
  logic [4:0]         tp_idx;
  logic [4:0]         op_idx;
  logic               send_ok;
  logic               tx_ok;
  logic               dresp_ok;
  logic               len_ok;
  logic [10:0]        hdr_len;
  logic [15:0]        frame_len;
  logic [7:0]         type_code;
  logic [7:0]         body_byte;
  logic               is_dresp;

  afc_rx_parser u_parser (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rx      (ser_rx),
    .ev      (ev)
  );

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign ser_tx        = s.out;

  // send-data field walk: path length, path, type length, type, transport, options
  assign ct_idx = s.tx_mem[0][4:0] + 5'h01;
  assign tp_idx = ct_idx + s.tx_mem[ct_idx][4:0] + 5'h01;
  assign op_idx = tp_idx + 5'h01;
  assign send_ok = (s.tx_mem[ct_idx] <= `AFC_CT_MAX)
                 && (s.tx_mem[tp_idx] == 8'h00)
                 && (s.tx_mem[op_idx] <= `AFC_OPT_MAX);
  assign tx_ok = (s.tx_mem[`AFC_BUF_PROTO] <= `AFC_PROTO_MAX)
               && ((s.tx_mem[`AFC_BUF_TXOPT] & `AFC_TXOPT_RSVD) == 8'h00)
               && (s.tx_len >= `AFC_TX_FIXED)
               && ((s.tx_len - `AFC_TX_FIXED) <= `AFC_TX_PAYLOAD_MAX);
  assign dresp_ok = s.req_pending && (s.req_id != 8'h00);
  assign len_ok = (s.tx_len <= `AFC_BUF_DEPTH);

  assign is_dresp  = (s.kind == AFC_KIND_DRESP);
  assign hdr_len   = is_dresp ? `AFC_HDR_DRESP : `AFC_HDR_PLAIN;
  assign frame_len = {5'h00, hdr_len + s.tx_len};
  assign type_code = (s.kind == AFC_KIND_SEND) ? `AFC_TYPE_SEND :
                     is_dresp ? `AFC_TYPE_DRESP : `AFC_TYPE_TX;
  assign body_byte = (s.idx == 11'h000) ? type_code :
                     (s.idx == 11'h001) ? s.frame_id :
                     (is_dresp && s.idx == 11'h002) ? s.req_id :
                     (is_dresp && s.idx == 11'h003) ? 8'h00 :
                     s.tx_mem[5'(s.idx - hdr_len)];

  always_comb begin
    logic [31:0] status;
    logic [31:0] rd;
    logic [1:0]  rresp;
    logic        wmap;
    status = 32'h0000_0000;
    rd = 32'h0000_0000;
    rresp = `AFC_RESP_OKAY;
    wmap = 1'b1;
    next_s = s;
    next_s.awready = 1'b0;
    next_s.wready = 1'b0;
    next_s.arready = 1'b0;

    status[`AFC_ST_BUSY]   = (s.st != AFC_TX_IDLE);
    status[`AFC_ST_RXRDY]  = s.rx_ready;
    status[`AFC_ST_PEND]   = s.req_pending;
    status[`AFC_ST_BADSUM] = s.bad_sum;
    status[`AFC_ST_REJECT] = s.rejected;
    status[`AFC_ST_LATE]   = s.late;
    status[`AFC_ST_LEGACY] = s.legacy_seen;

    // write channel: address and data taken together, one write at a time
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_wvalid && !s.bvalid && !s.awready) begin
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.awready) begin
      unique case ({s_axi_awaddr[7:2], 2'b00})
        `AFC_REG_CTRL: begin
          if (s_axi_wstrb[0] && s_axi_wdata[`AFC_CTRL_GO] && s.st == AFC_TX_IDLE) begin
            next_s.kind = afc_kind_type'(s_axi_wdata[2:1]);
            if (len_ok && ((s_axi_wdata[2:1] == AFC_KIND_TX && tx_ok)
                || (s_axi_wdata[2:1] == AFC_KIND_SEND && send_ok)
                || (s_axi_wdata[2:1] == AFC_KIND_DRESP && dresp_ok))) begin
              next_s.st = AFC_TX_START;
              next_s.idx = 11'h000;
              next_s.csum = 8'h00;
            end else begin
              next_s.rejected = 1'b1;
            end
          end
        end
        `AFC_REG_ID: if (s_axi_wstrb[0]) next_s.frame_id = s_axi_wdata[7:0];
        `AFC_REG_TXLEN: begin
          if (s_axi_wstrb[0]) begin
            next_s.tx_len = s_axi_wdata[10:0];
            next_s.tx_wptr = 5'h00;
          end
        end
        `AFC_REG_TXDATA: begin
          if (s_axi_wstrb[0]) begin
            next_s.tx_mem[s.tx_wptr] = s_axi_wdata[7:0];
            next_s.tx_wptr = s.tx_wptr + 5'h01;
          end
        end
        `AFC_REG_STATUS: begin
          // write one to clear; events below win over a same-cycle clear
          if (s_axi_wdata[`AFC_ST_RXRDY])  next_s.rx_ready = 1'b0;
          if (s_axi_wdata[`AFC_ST_BADSUM]) next_s.bad_sum = 1'b0;
          if (s_axi_wdata[`AFC_ST_REJECT]) next_s.rejected = 1'b0;
          if (s_axi_wdata[`AFC_ST_LATE])   next_s.late = 1'b0;
          if (s_axi_wdata[`AFC_ST_LEGACY]) next_s.legacy_seen = 1'b0;
        end
        `AFC_REG_CONFIG: if (s_axi_wstrb[0]) next_s.fmt = s_axi_wdata[1:0];
        `AFC_REG_SRC_HI, `AFC_REG_SRC_LO, `AFC_REG_RXINFO, `AFC_REG_REQID: wmap = 1'b1;
        default: wmap = (s_axi_awaddr[7:6] == `AFC_RXWIN_SEL);
      endcase
      next_s.bvalid = 1'b1;
      next_s.bresp = wmap ? `AFC_RESP_OKAY : `AFC_RESP_DECERR;
    end

    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid && !s.arready) begin
      next_s.arready = 1'b1;
    end
    if (s.arready) begin
      unique case ({s_axi_araddr[7:2], 2'b00})
        `AFC_REG_CTRL:   rd = {29'h0, s.kind, status[`AFC_ST_BUSY]};
        `AFC_REG_ID:     rd = {24'h0, s.frame_id};
        `AFC_REG_TXLEN:  rd = {21'h0, s.tx_len};
        `AFC_REG_TXDATA: rd = {27'h0, s.tx_wptr};
        `AFC_REG_STATUS: rd = status;
        `AFC_REG_CONFIG: rd = {30'h0, s.fmt};
        `AFC_REG_SRC_HI: rd = s.src[63:32];
        `AFC_REG_SRC_LO: rd = s.src[31:0];
        `AFC_REG_RXINFO: rd = {5'h0, s.rx_cnt, s.ropt, s.rssi};
        `AFC_REG_REQID:  rd = {24'h0, s.req_id};
        default: begin
          if (s_axi_araddr[7:6] == `AFC_RXWIN_SEL) begin
            rd = {24'h0, s.rx_mem[s_axi_araddr[5:2]]};
          end else begin
            rresp = `AFC_RESP_DECERR;
          end
        end
      endcase
      next_s.rdata = rd;
      next_s.rresp = rresp;
      next_s.rvalid = 1'b1;
    end

    // framer: load a byte, hold it until taken, then step
    if (s.st != AFC_TX_IDLE && !s.out.valid) begin
      next_s.out.valid = 1'b1;
      unique case (s.st)
        AFC_TX_START:  next_s.out.data = `AFC_START_BYTE;
        AFC_TX_LEN_HI: next_s.out.data = frame_len[15:8];
        AFC_TX_LEN_LO: next_s.out.data = frame_len[7:0];
        AFC_TX_BODY: begin
          next_s.out.data = body_byte;
          next_s.csum = s.csum + body_byte;
        end
        AFC_TX_SUM:    next_s.out.data = `AFC_SUM_BASE - s.csum;
        default:       next_s.out.valid = 1'b0;
      endcase
    end
    if (s.out.valid && ser_tx_ready) begin
      next_s.out.valid = 1'b0;
      unique case (s.st)
        AFC_TX_START:  next_s.st = AFC_TX_LEN_HI;
        AFC_TX_LEN_HI: next_s.st = AFC_TX_LEN_LO;
        AFC_TX_LEN_LO: next_s.st = AFC_TX_BODY;
        AFC_TX_BODY: begin
          next_s.idx = s.idx + 11'h001;
          if ({5'h00, s.idx + 11'h001} == frame_len) begin
            next_s.st = AFC_TX_SUM;
          end
        end
        AFC_TX_SUM: begin
          next_s.st = AFC_TX_IDLE;
          if (is_dresp) begin
            next_s.req_pending = 1'b0;
          end
        end
        default: next_s.st = AFC_TX_IDLE;
      endcase
    end

    // response deadline for a pending device request
    if (s.req_pending && !s.late) begin
      next_s.timer = s.timer + 28'h0000001;
      if (s.timer == 28'(RESP_TIMEOUT_CYCLES - 1)) begin
        next_s.late = 1'b1;
      end
    end

    // receive: only the request id waits in a working register for a good checksum; legacy fields are stored as they arrive
    if (ev.strobe) begin
      if (ev.offset == `AFC_OFF_TYPE) begin
        next_s.rtype = ev.value;
        if (ev.value == `AFC_TYPE_LEGACY) begin
          next_s.rx_cnt = 11'h000;
          next_s.rx_ready = 1'b0;
        end
      end else if (s.rtype == `AFC_TYPE_LEGACY) begin
        if (ev.offset <= `AFC_OFF_ADDR_LAST) begin
          next_s.src = {s.src[55:0], ev.value};
        end else if (ev.offset == `AFC_OFF_RSSI) begin
          next_s.rssi = ev.value;
        end else if (ev.offset == `AFC_OFF_ROPT) begin
          next_s.ropt = ev.value;
        end else begin
          if (s.rx_cnt < `AFC_RXBUF_DEPTH) begin
            next_s.rx_mem[s.rx_cnt[3:0]] = ev.value;
          end
          next_s.rx_cnt = s.rx_cnt + 11'h001;
        end
      end else if (s.rtype == `AFC_TYPE_DREQ && ev.offset == `AFC_OFF_REQID) begin
        next_s.req_id_work = ev.value;
      end
    end
    if (ev.done) begin
      if (!ev.good) begin
        next_s.bad_sum = 1'b1;
      end else if (s.rtype == `AFC_TYPE_LEGACY && s.fmt == `AFC_LEGACY_FMT) begin
        next_s.rx_ready = 1'b1;
        next_s.legacy_seen = 1'b1;
      end else if (s.rtype == `AFC_TYPE_DREQ) begin
        next_s.req_id = s.req_id_work;
        next_s.req_pending = 1'b1;
        next_s.timer = 28'h0000000;
        next_s.late = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= AFC_TX_IDLE;
      s.fmt <= `AFC_FMT_RST;
    end else begin
      s <= next_s;
    end
  end
endmodule

// file: test/afc_host_ctrl_assertions.sv
// afc_host_ctrl_assertions: port checks of the frame codec host.
// assumes afc_pkg compiled first; bound into every afc_host_ctrl.
module afc_host_ctrl_assertions
  import afc_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic [7:0]   s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic [3:0]   s_axi_wstrb,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [7:0]   s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire afc_byte_type ser_tx,
  input wire logic         ser_tx_ready,
  input wire afc_byte_type ser_rx
);
  logic [15:0] idx;
  logic [15:0] flen;
  logic [7:0]  sum;
  logic        last;
  // position of the outgoing byte within its frame
  assign last = (idx > 16'h0002) && (idx == flen + 16'h0003);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx  <= 16'h0000;
      flen <= 16'h0000;
      sum  <= 8'h00;
    end else if (ser_tx.valid && ser_tx_ready) begin
      idx <= last ? 16'h0000 : idx + 16'h0001;
      flen[15:8] <= (idx == 16'h0001) ? ser_tx.data : flen[15:8];
      flen[7:0] <= (idx == 16'h0002) ? ser_tx.data : flen[7:0];
      sum <= last ? 8'h00 : ((idx > 16'h0002) ? sum + ser_tx.data : sum);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_taken;
    ser_tx.valid && ser_tx_ready;
  endsequence
  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  a_start_byte: assert property (ser_tx.valid && idx == 16'h0000 |-> ser_tx.data == 8'h7E)
    else $error("frame does not open with start byte");
  a_sum_byte: assert property (ser_tx.valid && last |-> ser_tx.data == 8'hFF - sum)
    else $error("frame check byte wrong");
  a_tx_hold: assert property (ser_tx.valid && !ser_tx_ready |=> ser_tx.valid && $stable(ser_tx))
    else $error("serial byte changed before taken");
  a_tx_gap: assert property (s_taken |=> !ser_tx.valid)
    else $error("no idle cycle after serial byte");
  a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer late");
  a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
    else $error("address and data taken apart");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
endmodule
bind afc_host_ctrl afc_host_ctrl_assertions u_afc_host_ctrl_assertions (.*);

// file: test/afc_dev_model.sv
// afc_dev_model: behavioural wireless module on the host's serial bytes.
// assumes same-clock byte streams; the bench calls its tasks and reads got.
module afc_dev_model
  import afc_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         slow,
  input wire afc_byte_type ser_tx,
  output logic             ser_tx_ready,
  output afc_byte_type     ser_rx
);
  logic [7:0] got[$];
  logic       pace = 1'b0;
  assign ser_tx_ready = !slow || pace;
  always @(posedge aclk) begin
    pace <= aresetn && !pace;
    if (aresetn && ser_tx.valid && ser_tx_ready) begin
      got.push_back(ser_tx.data);
    end
  end
  // never answers with a status frame
  initial ser_rx = '0;
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [7:0] f[$];
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    f = {8'h7E, 8'(b.size() >> 8), 8'(b.size()), b};
    f.push_back(bad ? 8'h00 - s : 8'hFF - s);
    foreach (f[i]) begin
      @(posedge aclk);
      ser_rx <= '{valid: 1'b1, data: f[i]};
    end
    @(posedge aclk);
    ser_rx <= '{valid: 1'b0, data: ~f[f.size() - 1]};
  endtask
  task automatic dev_request(input logic [7:0] fid, input logic [7:0] rid);
    send('{8'hB9, fid, rid, 8'h00}, 1'b0);
  endtask
  // the host flags it ready only at format 2; its fields are stored at any format
  task automatic legacy(input logic [63:0] a, input logic [7:0] rssi, input logic [7:0] opt,
                        input logic [7:0] pl[$], input logic bad);
    logic [7:0] b[$];
    b = '{8'h80};
    for (int i = 7; i >= 0; i--) b.push_back(a[i*8 +: 8]);
    b = {b, rssi, opt, pl};
    send(b, bad);
  endtask
endmodule

// file: test/afc_host_ctrl_tb_top.sv
// afc_host_ctrl_tb_top: register-level bench of the frame codec host.
// assumes the design, checker and afc_dev_model are compiled first.
module afc_host_ctrl_tb_top
  import afc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LATE = 60;
  localparam int LIMIT = 30000;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [7:0]   s_axi_awaddr = 8'h00;
  logic         s_axi_awvalid = 1'b0;
  logic         s_axi_awready;
  logic [31:0]  s_axi_wdata = 32'h0;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic         s_axi_wvalid = 1'b0;
  logic         s_axi_wready;
  logic [1:0]   s_axi_bresp;
  logic         s_axi_bvalid;
  logic         s_axi_bready = 1'b0;
  logic [7:0]   s_axi_araddr = 8'h00;
  logic         s_axi_arvalid = 1'b0;
  logic         s_axi_arready;
  logic [31:0]  s_axi_rdata;
  logic [1:0]   s_axi_rresp;
  logic         s_axi_rvalid;
  logic         s_axi_rready = 1'b0;
  afc_byte_type ser_tx;
  logic         ser_tx_ready;
  afc_byte_type ser_rx;
  logic         slow = 1'b0;
  int           n_errors = 0;
  int           checks_done = 0;
  int           cycles = 0;
  logic [7:0]   q[$];
  logic [7:0]   e[$];
  logic [7:0]   pr[4] = '{8'h00, 8'h01, 8'h02, 8'h00};
  logic [7:0]   op[4] = '{8'h00, 8'h02, 8'h00, 8'h01};
  afc_host_ctrl #(.RESP_TIMEOUT_CYCLES(LATE)) u_afc_host_ctrl (.*);
  afc_dev_model u_afc_dev_model (.aclk(aclk), .aresetn(aresetn), .slow(slow),
                                 .ser_tx(ser_tx), .ser_tx_ready(ser_tx_ready), .ser_rx(ser_rx));
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task automatic send_go(input logic [1:0] k, input logic [7:0] id, input logic [7:0] b[$]);
    wr(8'h04, {24'h0, id}, 2'h0);
    wr(8'h08, 32'(b.size()), 2'h0);
    foreach (b[i]) wr(8'h0C, {24'h0, b[i]}, 2'h0);
    wr(8'h00, {29'h0, k, 1'b1}, 2'h0);
  endtask
  task automatic expect_frame(input logic [7:0] b[$]);
    logic [7:0] f[$];
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    f = {8'h7E, 8'(b.size() >> 8), 8'(b.size()), b};
    f.push_back(8'hFF - s);
    while (u_afc_dev_model.got.size() < f.size()) @(posedge aclk);
    foreach (f[i]) chk({24'h0, u_afc_dev_model.got[i]}, {24'h0, f[i]});
    u_afc_dev_model.got.delete();
  endtask
  // nothing may leave the serial port after a refused go
  task automatic expect_reject(input logic [31:0] st);
    rd(8'h10, st | 32'h10, 2'h0);
    chk(32'(u_afc_dev_model.got.size()), 32'h0);
    wr(8'h10, 32'h10, 2'h0);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h14, 32'h0, 2'h0);
    rd(8'h30, 32'h0, 2'h3);
    wr(8'h30, 32'h1, 2'h3);
    s_axi_wstrb <= 4'h0;
    wr(8'h04, 32'hFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 32'h0, 2'h0);
    $display("test registers done");
    slow <= 1'b1;
    for (int o = 0; o <= 4; o++) begin
      q = '{8'h02, 8'h61, 8'h62, 8'h01, 8'h78, 8'h00, 8'(o), 8'h55};
      e = {8'h28, 8'(o), q};
      send_go(2'h1, 8'(o), q);
      if (o < 4) expect_frame(e);
      else expect_reject(32'h0);
    end
    q = '{8'h02, 8'h61, 8'h62, 8'h11, 8'h78, 8'h00, 8'h00};
    send_go(2'h1, 8'h01, q);
    expect_reject(32'h0);
    $display("test send data done");
    for (int i = 0; i < 4; i++) begin
      q = '{8'hC0, 8'hA8, 8'h00, 8'h64, 8'h26, 8'h16, 8'h26, 8'h16};
      q = {q, pr[i], op[i], 8'h48, 8'h65};
      e = {8'h20, 8'h03, q};
      send_go(2'h0, 8'h03, q);
      if (i < 2) expect_frame(e);
      else expect_reject(32'h0);
    end
    send_go(2'h3, 8'h03, q);
    expect_reject(32'h0);
    slow <= 1'b0;
    $display("test transmit done");
    u_afc_dev_model.dev_request(8'h01, 8'h5A);
    rd(8'h10, 32'h04, 2'h0);
    rd(8'h24, 32'h5A, 2'h0);
    q = '{8'h48, 8'h69};
    e = {8'h2A, 8'h07, 8'h5A, 8'h00, q};
    send_go(2'h2, 8'h07, q);
    expect_frame(e);
    rd(8'h10, 32'h0, 2'h0);
    send_go(2'h2, 8'h08, q);
    expect_reject(32'h0);
    $display("test device response done");
    u_afc_dev_model.legacy(64'h0102030405060708, 8'h28, 8'h00, q, 1'b0);
    rd(8'h10, 32'h0, 2'h0);
    wr(8'h14, 32'h2, 2'h0);
    q = '{8'h41, 8'h42, 8'h43};
    u_afc_dev_model.legacy(64'h0011223344556677, 8'h28, 8'h06, q, 1'b0);
    rd(8'h10, 32'h42, 2'h0);
    rd(8'h18, 32'h00112233, 2'h0);
    rd(8'h1C, 32'h44556677, 2'h0);
    rd(8'h20, 32'h00030628, 2'h0);
    rd(8'h40, 32'h41, 2'h0);
    rd(8'h48, 32'h43, 2'h0);
    u_afc_dev_model.legacy(64'hFFEEDDCCBBAA9988, 8'h30, 8'h02, q, 1'b1);
    rd(8'h10, 32'h48, 2'h0);
    u_afc_dev_model.legacy(64'h8877665544332211, 8'h30, 8'h02, q, 1'b0);
    rd(8'h18, 32'h88776655, 2'h0);
    rd(8'h10, 32'h4A, 2'h0);
    wr(8'h10, 32'h7A, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    $display("test legacy receive done");
    u_afc_dev_model.dev_request(8'h02, 8'h00);
    repeat (LATE + 10) @(posedge aclk);
    rd(8'h10, 32'h24, 2'h0);
    send_go(2'h2, 8'h09, q);
    expect_reject(32'h24);
    $display("test response timeout done");
    results();
  end
endmodule
